// file: hw/scd_defines.svh
// Constants for the command decoder: pin widths, field positions and burst settings
`ifndef SCD_DEFINES_SVH
`define SCD_DEFINES_SVH
`define SCD_BG_W        2
`define SCD_BA_W        2
`define SCD_ADDR_W      18
`define SCD_CMD_MRS     3'h0
`define SCD_CMD_REF     3'h1
`define SCD_CMD_PRE     3'h2
`define SCD_CMD_RFU     3'h3
`define SCD_CMD_WR      3'h4
`define SCD_CMD_RD      3'h5
`define SCD_CMD_ZQ      3'h6
`define SCD_CMD_NOP     3'h7
`define SCD_AP_BIT      10
`define SCD_BC_BIT      12
`define SCD_A14_BIT     14
`define SCD_A17_BIT     17
`define SCD_MR_BURST    3'h0
`define SCD_OTF_CODE    2'h1
`define SCD_BC4_CODE    2'h2
`define SCD_VREF_STEPS  6'h32
`define SCD_BEATS_BL8   4'h8
`define SCD_BEATS_BC4   4'h4
`define SCD_LINK_SYNC   2
`endif

// file: hw/scd_pkg.sv
// Types shared by the command decoder modules
package scd_pkg;
  typedef enum logic [3:0] {
    CMD_NONE, CMD_MRS, CMD_REF, CMD_PRE, CMD_PREA, CMD_ACT, CMD_WR, CMD_RD,
    CMD_NOP, CMD_ZQL, CMD_ZQS, CMD_RFU, CMD_SRE, CMD_PDE, CMD_EXIT
  } scd_cmd_e;
  typedef enum logic [1:0] {ST_ACTIVE, ST_SLEEP, ST_SELF_REFRESH} scd_power_e;
  typedef struct packed {
    logic        cke;
    logic        cs_low;
    logic        activate_low;
    logic [2:0]  strobes;
    logic [1:0]  bank_cluster_index;
    logic [1:0]  bank;
    logic [17:0] addr;
  } scd_pins_s;
  typedef struct packed {
    scd_cmd_e    cmd;
    logic [1:0]  bank_cluster_index;
    logic [1:0]  bank;
    logic [17:0] addr;
    logic        auto_close_flag;
    logic        burst_long;
  } scd_decoded_s;
endpackage

// file: hw/scd_pin_sampler.sv
// Two-stage synchroniser for the command pins and rising-edge finder for the link clock
`timescale 1ns/1ps
`include "scd_defines.svh"
module scd_pin_sampler (
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic              link_clk,
  input  wire scd_pkg::scd_pins_s pins_in,
  output logic                   link_rise,
  output scd_pkg::scd_pins_s     pins_out
);
  scd_pkg::scd_pins_s pins_meta_q, pins_meta_d, pins_sync_q, pins_sync_d;
  logic [2:0] clk_sh_q, clk_sh_d;

  // Next values: first stage read only by second stage
  always_comb
  begin
    pins_meta_d = pins_in;
    pins_sync_d = pins_meta_q;
    clk_sh_d    = {clk_sh_q[1:0], link_clk};
  end

  // Registers; reset clears pins to an idle deselect level
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      pins_meta_q <= {2'h3, 26'h0000000};
      pins_sync_q <= {2'h3, 26'h0000000};
      clk_sh_q    <= 3'h7; // All ones: a link clock already high is not taken as a fresh edge
    end
    else
    begin
      pins_meta_q <= pins_meta_d;
      pins_sync_q <= pins_sync_d;
      clk_sh_q    <= clk_sh_d;
    end
  end

  // Edge seen on synchronised stages only; pins lag clock by same depth
  assign link_rise = clk_sh_q[1] & ~clk_sh_q[2];
  assign pins_out  = pins_sync_q;
endmodule // scd_pin_sampler

// file: hw/scd_burst_counter.sv
// Counts the beats of a running read or write burst so it cannot be cut short
`timescale 1ns/1ps
`include "scd_defines.svh"
module scd_burst_counter (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       beat,
  input  wire logic       start,
  input  wire logic [3:0] beats,
  output logic            busy
);
  logic [3:0] left_q, left_d;

  // A start while busy is ignored: the burst in flight always completes
  always_comb
  begin
    left_d = left_q;
    if (left_q != 4'h0 && beat)
      left_d = left_q - 4'h1;
    else if (left_q == 4'h0 && start)
      left_d = beats;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      left_q <= 4'h0;
    else
      left_q <= left_d;
  end

  assign busy = (left_q != 4'h0);
endmodule // scd_burst_counter

// file: hw/scd_command_decoder.sv
// Command decoder of a synchronous DRAM: sampling, decode, mode registers, power states
`timescale 1ns/1ps
`include "scd_defines.svh"
// Overview of operation
// - Commands decode from select, activate, three strobes and clock enable at link edge.
// - Activate high: pins are strobes; activate low: pins are row bits A16..A14.
// - Top bits of bank, group, row, column fields depend on density and width.
// - Reset input active low; controller holds it high during normal operation.
// - Bank group plus bank pick the single bank a bank command acts on.
// - Mode register set writes opcode to register chosen by group and bank.
// - A started read or write burst always runs to its end.
// - Fixed or on-the-fly burst length comes from a mode register setting.
// - Decode ignores termination input; termination is off in self-refresh.
// - Device may detect self-refresh exit synchronously; this one does so.
// - No refresh is performed while in power-down.
// - Reference calibration value offers fifty settings per range, about 0.65% each.
module scd_command_decoder (
  input  wire logic                  clock,
  input  wire logic                  rst_b,
  input  wire logic                  link_clk,
  input  wire logic                  cke,
  input  wire logic                  cs_low,
  input  wire logic                  activate_low,
  input  wire logic [2:0]            strobes,
  input  wire logic [1:0]            bank_cluster_index,
  input  wire logic [1:0]            bank,
  input  wire logic [17:0]           addr,
  input  wire logic                  on_die_termination,
  output scd_pkg::scd_decoded_s      cmd_out,
  output logic                       cmd_valid,
  output logic [3:0]                 bank_onehot,
  output logic [3:0]                 cluster_onehot,
  output logic                       mode_write,
  output logic [2:0]                 mode_sel,
  output logic [17:0]                mode_data,
  output logic                       on_the_fly,
  output logic                       burst_busy,
  output logic                       refresh_pulse,
  output logic                       odt_active,
  output logic                       in_sleep,
  output logic                       in_self_refresh,
  output logic                       vref_out_of_range
);
  scd_pkg::scd_pins_s    pins_raw, pins_s;
  scd_pkg::scd_pins_s    prev_q, prev_d;
  scd_pkg::scd_power_e   pwr_q, pwr_d;
  scd_pkg::scd_decoded_s dec, cmd_q, cmd_d;
  logic                  link_rise;
  logic                  valid_q, valid_d;
  logic [3:0]            bank_q, bank_d, clus_q, clus_d;
  logic                  mw_q, mw_d;
  logic [2:0]            msel_q, msel_d;
  logic [17:0]           mdata_q, mdata_d;
  logic [1:0]            burst_cfg_q, burst_cfg_d;
  logic                  otf_q, otf_d;
  logic                  ref_q, ref_d;
  logic                  odt_q, odt_d;
  logic                  odt_meta_q, odt_meta_d, odt_sync_q, odt_sync_d;
  logic                  sleep_q, sleep_d, sref_q, sref_d;
  logic                  vrange_q, vrange_d;
  logic                  burst_start, busy_w;
  logic [3:0]            burst_beats;

  assign pins_raw = '{cke: cke, cs_low: cs_low, activate_low: activate_low, strobes: strobes,
                      bank_cluster_index: bank_cluster_index, bank: bank, addr: addr};

  // Pins cross into the core clock before anything decodes them
  scd_pin_sampler u_sampler (
    .clock    (clock),
    .rst_b    (rst_b),
    .link_clk (link_clk),
    .pins_in  (pins_raw),
    .link_rise(link_rise),
    .pins_out (pins_s)
  );

  // Combinational decode of one sampled edge; termination input never looked at
  always_comb
  begin
    dec                    = '0;
    dec.cmd                = scd_pkg::CMD_NONE;
    dec.bank_cluster_index = pins_s.bank_cluster_index;
    dec.bank               = pins_s.bank;
    dec.addr               = pins_s.addr;
    dec.auto_close_flag    = pins_s.addr[`SCD_AP_BIT];
    dec.burst_long         = (burst_cfg_q == `SCD_OTF_CODE) ? pins_s.addr[`SCD_BC_BIT]
                                                            : (burst_cfg_q != `SCD_BC4_CODE);
    // Select and activate fields hold pin levels: low means asserted
    if (prev_q.cke && !pins_s.cke)
    begin
      // Clock enable falling: refresh encoding or deselect only
      if (!pins_s.cs_low && pins_s.activate_low && pins_s.strobes == `SCD_CMD_REF)
        dec.cmd = scd_pkg::CMD_SRE;
      else if (pins_s.cs_low)
        dec.cmd = scd_pkg::CMD_PDE;
    end
    else if (!prev_q.cke && pins_s.cke)
    begin
      if (pins_s.cs_low)
        dec.cmd = scd_pkg::CMD_EXIT;
    end
    else if (prev_q.cke && pins_s.cke && !pins_s.cs_low)
    begin
      if (!pins_s.activate_low)
      begin
        dec.cmd = scd_pkg::CMD_ACT;
        dec.addr[16:`SCD_A14_BIT] = pins_s.strobes;
      end
      else
      begin
        case (pins_s.strobes)
          `SCD_CMD_MRS: dec.cmd = scd_pkg::CMD_MRS;
          `SCD_CMD_REF: dec.cmd = scd_pkg::CMD_REF;
          `SCD_CMD_PRE: dec.cmd = pins_s.addr[`SCD_AP_BIT] ? scd_pkg::CMD_PREA : scd_pkg::CMD_PRE;
          `SCD_CMD_WR:  dec.cmd = scd_pkg::CMD_WR;
          `SCD_CMD_RD:  dec.cmd = scd_pkg::CMD_RD;
          `SCD_CMD_ZQ:  dec.cmd = pins_s.addr[`SCD_AP_BIT] ? scd_pkg::CMD_ZQL : scd_pkg::CMD_ZQS;
          `SCD_CMD_NOP: dec.cmd = scd_pkg::CMD_NOP;
          default:      dec.cmd = scd_pkg::CMD_RFU;
        endcase
      end
    end
  end

  // Burst tracker: start only for reads/writes, beats per burst from length choice
  assign burst_start = link_rise && pwr_q == scd_pkg::ST_ACTIVE &&
                       (dec.cmd == scd_pkg::CMD_WR || dec.cmd == scd_pkg::CMD_RD);
  assign burst_beats = dec.burst_long ? `SCD_BEATS_BL8 : `SCD_BEATS_BC4;

  scd_burst_counter u_burst (
    .clock (clock),
    .rst_b (rst_b),
    .beat  (link_rise),
    .start (burst_start),
    .beats (burst_beats),
    .busy  (busy_w)
  );

  // Next state: power mode, mode register capture, registered outputs
  always_comb
  begin
    prev_d      = prev_q;
    pwr_d       = pwr_q;
    cmd_d       = cmd_q;
    valid_d     = 1'b0;
    bank_d      = bank_q;
    clus_d      = clus_q;
    mw_d        = 1'b0;
    msel_d      = msel_q;
    mdata_d     = mdata_q;
    burst_cfg_d = burst_cfg_q;
    ref_d       = 1'b0;
    vrange_d    = vrange_q;
    if (link_rise)
    begin
      prev_d = pins_s;
      case (pwr_q)
        scd_pkg::ST_ACTIVE:
        begin
          if (dec.cmd == scd_pkg::CMD_SRE)
            pwr_d = scd_pkg::ST_SELF_REFRESH;
          else if (dec.cmd == scd_pkg::CMD_PDE)
            pwr_d = scd_pkg::ST_SLEEP;
          if (dec.cmd != scd_pkg::CMD_NONE)
          begin
            cmd_d   = dec;
            valid_d = 1'b1;
          end
          // One-hot bank and cluster select for bank-directed commands
          if (dec.cmd == scd_pkg::CMD_ACT || dec.cmd == scd_pkg::CMD_PRE ||
              dec.cmd == scd_pkg::CMD_WR || dec.cmd == scd_pkg::CMD_RD)
          begin
            bank_d = 4'h1 << dec.bank;
            clus_d = 4'h1 << dec.bank_cluster_index;
          end
          if (dec.cmd == scd_pkg::CMD_MRS)
          begin
            mw_d    = 1'b1;
            msel_d  = {dec.bank_cluster_index[0], dec.bank};
            mdata_d = dec.addr;
            if (msel_d == `SCD_MR_BURST)
              burst_cfg_d = dec.addr[1:0];
            // Calibration value above the fifty legal steps is flagged; other registers leave it
            if (msel_d == 3'h6)
              vrange_d = (dec.addr[5:0] >= `SCD_VREF_STEPS);
          end
          if (dec.cmd == scd_pkg::CMD_REF)
            ref_d = 1'b1;
        end
        // Sleep and self-refresh wait only for a deselect with clock enable rising
        scd_pkg::ST_SLEEP, scd_pkg::ST_SELF_REFRESH:
        begin
          if (dec.cmd == scd_pkg::CMD_EXIT)
          begin
            pwr_d   = scd_pkg::ST_ACTIVE;
            cmd_d   = dec;
            valid_d = 1'b1;
          end
        end
        default: pwr_d = scd_pkg::ST_ACTIVE;
      endcase
    end
    // Sleep never refreshes; self-refresh keeps termination off
    if (pwr_q == scd_pkg::ST_SLEEP)
      ref_d = 1'b0;
  end

  // Termination pin is asynchronous as well, so it crosses two flops before use
  assign odt_meta_d = on_die_termination;
  assign odt_sync_d = odt_meta_q;
  assign odt_d      = odt_sync_q && pwr_q != scd_pkg::ST_SELF_REFRESH;
  assign otf_d      = (burst_cfg_q == `SCD_OTF_CODE);
  // State flags registered from the next state so they switch together with it
  assign sleep_d    = (pwr_d == scd_pkg::ST_SLEEP);
  assign sref_d     = (pwr_d == scd_pkg::ST_SELF_REFRESH);

  // Registers only; termination pin synchronised via odt path is level-only
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      // Deselect with clock enable high, so the first edge is not taken as an exit
      prev_q      <= {2'h3, 26'h0000000};
      pwr_q       <= scd_pkg::ST_ACTIVE;
      cmd_q       <= '0;
      valid_q     <= 1'b0;
      bank_q      <= 4'h0;
      clus_q      <= 4'h0;
      mw_q        <= 1'b0;
      msel_q      <= 3'h0;
      mdata_q     <= 18'h00000;
      burst_cfg_q <= 2'h0;
      otf_q       <= 1'b0;
      ref_q       <= 1'b0;
      odt_q       <= 1'b0;
      odt_meta_q  <= 1'b0;
      odt_sync_q  <= 1'b0;
      sleep_q     <= 1'b0;
      sref_q      <= 1'b0;
      vrange_q    <= 1'b0;
    end
    else
    begin
      prev_q      <= prev_d;
      pwr_q       <= pwr_d;
      cmd_q       <= cmd_d;
      valid_q     <= valid_d;
      bank_q      <= bank_d;
      clus_q      <= clus_d;
      mw_q        <= mw_d;
      msel_q      <= msel_d;
      mdata_q     <= mdata_d;
      burst_cfg_q <= burst_cfg_d;
      otf_q       <= otf_d;
      ref_q       <= ref_d;
      odt_q       <= odt_d;
      odt_meta_q  <= odt_meta_d;
      odt_sync_q  <= odt_sync_d;
      sleep_q     <= sleep_d;
      sref_q      <= sref_d;
      vrange_q    <= vrange_d;
    end
  end

  // Busy flag registered so every output leaves a flip-flop
  logic busy_q, busy_d;
  always_comb
  begin
    busy_d = busy_w;
  end
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      busy_q <= 1'b0;
    else
      busy_q <= busy_d;
  end

  assign cmd_out           = cmd_q;
  assign cmd_valid         = valid_q;
  assign bank_onehot       = bank_q;
  assign cluster_onehot    = clus_q;
  assign mode_write        = mw_q;
  assign mode_sel          = msel_q;
  assign mode_data         = mdata_q;
  assign on_the_fly        = otf_q;
  assign burst_busy        = busy_q;
  assign refresh_pulse     = ref_q;
  assign odt_active        = odt_q;
  assign in_sleep          = sleep_q;
  assign in_self_refresh   = sref_q;
  assign vref_out_of_range = vrange_q;
endmodule // scd_command_decoder

// file: tb/scd_decoder_chk.sv
// Concurrent checks on the outputs of the command decoder
`timescale 1ns/1ps
`include "scd_defines.svh"
module scd_decoder_chk (
  input wire logic                 clock,
  input wire logic                 rst_b,
  input wire scd_pkg::scd_decoded_s cmd_out,
  input wire logic                 cmd_valid,
  input wire logic [3:0]           bank_onehot,
  input wire logic [3:0]           cluster_onehot,
  input wire logic                 mode_write,
  input wire logic [2:0]           mode_sel,
  input wire logic [17:0]          mode_data,
  input wire logic                 on_the_fly,
  input wire logic                 burst_busy,
  input wire logic                 refresh_pulse,
  input wire logic                 odt_active,
  input wire logic                 in_sleep,
  input wire logic                 in_self_refresh
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  // Two cycles in self-refresh: the lagging termination output has caught up by then
  sequence s_sr_held;
    in_self_refresh [*2];
  endsequence

  // Pulses and their causes, tied to the decoded command
  property p_valid_pulse;
    cmd_valid |=> !cmd_valid;
  endproperty
  property p_refresh;
    refresh_pulse |-> cmd_valid && cmd_out.cmd == scd_pkg::CMD_REF;
  endproperty
  property p_no_ref_asleep;
    in_sleep || in_self_refresh |-> !refresh_pulse;
  endproperty
  property p_mode;
    mode_write |-> cmd_valid && cmd_out.cmd == scd_pkg::CMD_MRS
      && mode_sel == {cmd_out.bank_cluster_index[0], cmd_out.bank} && mode_data == cmd_out.addr;
  endproperty
  property p_bank;
    cmd_valid && cmd_out.cmd inside {scd_pkg::CMD_ACT, scd_pkg::CMD_WR, scd_pkg::CMD_RD, scd_pkg::CMD_PRE}
      |-> bank_onehot == (4'h1 << cmd_out.bank) && cluster_onehot == (4'h1 << cmd_out.bank_cluster_index);
  endproperty
  // Address bits that qualify the command
  property p_auto;
    cmd_valid && cmd_out.cmd inside {scd_pkg::CMD_WR, scd_pkg::CMD_RD}
      |-> cmd_out.auto_close_flag == cmd_out.addr[`SCD_AP_BIT];
  endproperty
  property p_otf;
    cmd_valid && on_the_fly && cmd_out.cmd inside {scd_pkg::CMD_WR, scd_pkg::CMD_RD}
      |-> cmd_out.burst_long == cmd_out.addr[`SCD_BC_BIT];
  endproperty
  property p_prea;
    cmd_valid && cmd_out.cmd inside {scd_pkg::CMD_PRE, scd_pkg::CMD_PREA}
      |-> (cmd_out.cmd == scd_pkg::CMD_PREA) == cmd_out.addr[`SCD_AP_BIT];
  endproperty
  // A burst of four beats still spans far more than eight core cycles
  property p_burst;
    $rose(burst_busy) |-> burst_busy [*8];
  endproperty
  property p_odt;
    s_sr_held |-> !odt_active;
  endproperty

  a_valid_pulse: assert property (p_valid_pulse)
    else $error("command pulse longer than one cycle");
  a_refresh: assert property (p_refresh)
    else $error("refresh pulse without refresh command");
  a_no_ref_asleep: assert property (p_no_ref_asleep)
    else $error("refresh while powered down");
  a_mode: assert property (p_mode)
    else $error("mode write target or data wrong");
  a_bank: assert property (p_bank)
    else $error("bank target wrong");
  a_auto: assert property (p_auto)
    else $error("auto close flag wrong");
  a_otf: assert property (p_otf)
    else $error("burst length choice wrong");
  a_prea: assert property (p_prea)
    else $error("precharge scope wrong");
  a_burst: assert property (p_burst)
    else $error("burst cut short");
  a_odt: assert property (p_odt)
    else $error("termination on in self refresh");
endmodule // scd_decoder_chk

// file: tb/scd_ctrl_model.sv
// Behavioural memory controller driving the command pins and the command clock
`timescale 1ns/1ps
module scd_ctrl_model (
  input  wire logic          clock,
  output logic               link_clk,
  output scd_pkg::scd_pins_s pins
);
  // Command clock runs free at one eighth of the core clock rate, at a fixed phase set by its 7 ns start delay
  initial
  begin
    link_clk = 1'b0;
    pins = {2'h3, 26'h0000000};
    #7;
    forever #160 link_clk = ~link_clk;
  end

  // One command over one rising command-clock edge, then deselect
  task issue(input scd_pkg::scd_pins_s p);
    scd_pkg::scd_pins_s cmd;
    scd_pkg::scd_pins_s rel;
    cmd = p;
    // Reserved top address bit is kept low on every mode register write
    if (!p.cs_low && p.activate_low && p.strobes == 3'h0)
      cmd.addr[17] = 1'b0;
    rel = ~cmd; // Released lines show the inverse, except clock enable, which keeps its level, and select, driven high
    rel.cke = p.cke;
    rel.cs_low = 1'b1;
    @(negedge link_clk);
    @(posedge clock);
    pins <= cmd;
    @(negedge link_clk);
    @(posedge clock);
    pins <= rel;
  endtask
endmodule // scd_ctrl_model

// file: tb/tb_top.sv
// Self-checking bench for the command decoder
`timescale 1ns/1ps
module tb_top;
  typedef struct packed
  {
    scd_pkg::scd_pins_s pins;
    scd_pkg::scd_cmd_e  cmd;
  } scd_row_s;
  logic                 clock;
  logic                 rst_b;
  logic                 link_clk;
  logic                 on_die_termination;
  scd_pkg::scd_pins_s   pins;
  scd_pkg::scd_pins_s   p;
  scd_pkg::scd_decoded_s cmd_out;
  scd_pkg::scd_decoded_s cap;
  logic                 cmd_valid, mode_write, on_the_fly, burst_busy, refresh_pulse;
  logic                 odt_active, in_sleep, in_self_refresh, vref_out_of_range;
  logic [3:0]           bank_onehot, cluster_onehot;
  logic [2:0]           mode_sel;
  logic [17:0]          mode_data;
  int                   mismatches = 0, total_checks = 0, n_valid = 0, n_ref = 0, cycles = 0, v0, r0;
  scd_row_s             rows[11];

  scd_ctrl_model u_ctrl (.clock(clock), .link_clk(link_clk), .pins(pins));
  scd_command_decoder DUT (.clock(clock), .rst_b(rst_b), .link_clk(link_clk), .cke(pins.cke),
    .cs_low(pins.cs_low), .activate_low(pins.activate_low), .strobes(pins.strobes),
    .bank_cluster_index(pins.bank_cluster_index), .bank(pins.bank), .addr(pins.addr),
    .on_die_termination(on_die_termination), .cmd_out(cmd_out), .cmd_valid(cmd_valid),
    .bank_onehot(bank_onehot), .cluster_onehot(cluster_onehot), .mode_write(mode_write),
    .mode_sel(mode_sel), .mode_data(mode_data), .on_the_fly(on_the_fly), .burst_busy(burst_busy),
    .refresh_pulse(refresh_pulse), .odt_active(odt_active), .in_sleep(in_sleep),
    .in_self_refresh(in_self_refresh), .vref_out_of_range(vref_out_of_range));

  task chk_v(input string what, input logic [17:0] exp, input logic [17:0] got);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task chk_cmd(input string what, input scd_pkg::scd_cmd_e exp, input scd_pkg::scd_cmd_e got);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  function automatic scd_pkg::scd_pins_s mk(input logic act, input logic [2:0] s, input logic [1:0] g,
    input logic [1:0] b, input logic [17:0] a);
    mk = {1'h1, 1'h0, act, s, g, b, a};
  endfunction
  // Issue and give the synchroniser and decode stages time to settle
  task send(input scd_pkg::scd_pins_s q);
    v0 = n_valid;
    r0 = n_ref;
    u_ctrl.issue(q);
    repeat (3) @(posedge clock);
    #1;
  endtask
  task stop_test;
    $display("Comparisons %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Capture each decoded command; a hang is cut short by the cycle ceiling
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cmd_valid === 1'b1)
    begin
      cap <= cmd_out;
      n_valid <= n_valid + 1;
    end
    if (refresh_pulse === 1'b1)
      n_ref <= n_ref + 1;
    if (cycles == 6000)
    begin
      mismatches++;
      stop_test();
    end
  end

  initial
  begin
    rst_b = 1'b0;
    on_die_termination = 1'b0;
    rows[0] = '{mk(1'h1, 3'h0, 2'h0, 2'h0, 18'h00001), scd_pkg::CMD_MRS};
    rows[1] = '{mk(1'h1, 3'h1, 2'h1, 2'h2, 18'h00000), scd_pkg::CMD_REF};
    rows[2] = '{mk(1'h1, 3'h2, 2'h2, 2'h3, 18'h00000), scd_pkg::CMD_PRE};
    rows[3] = '{mk(1'h1, 3'h2, 2'h0, 2'h0, 18'h00400), scd_pkg::CMD_PREA};
    rows[4] = '{mk(1'h0, 3'h5, 2'h3, 2'h1, 18'h00123), scd_pkg::CMD_ACT};
    rows[5] = '{mk(1'h1, 3'h4, 2'h1, 2'h1, 18'h01000), scd_pkg::CMD_WR};
    rows[6] = '{mk(1'h1, 3'h5, 2'h2, 2'h0, 18'h00408), scd_pkg::CMD_RD};
    rows[7] = '{mk(1'h1, 3'h6, 2'h0, 2'h1, 18'h00400), scd_pkg::CMD_ZQL};
    rows[8] = '{mk(1'h1, 3'h6, 2'h0, 2'h1, 18'h00000), scd_pkg::CMD_ZQS};
    rows[9] = '{mk(1'h1, 3'h7, 2'h1, 2'h0, 18'h00000), scd_pkg::CMD_NOP};
    rows[10] = '{mk(1'h1, 3'h3, 2'h1, 2'h3, 18'h00000), scd_pkg::CMD_RFU};
    repeat (1) @(posedge clock);
    #1;
    chk_v("reset_outputs", 18'h0, {cmd_valid, in_sleep, in_self_refresh, on_the_fly, burst_busy});
    @(posedge clock);
    rst_b <= 1'b1;
    foreach (rows[i])
    begin
      send(rows[i].pins);
      chk_v("pulses", 18'h1, 18'(n_valid - v0));
      chk_cmd("cmd", rows[i].cmd, cap.cmd);
      chk_v("target", {rows[i].pins.bank_cluster_index, rows[i].pins.bank}, {cap.bank_cluster_index, cap.bank});
      chk_v("refresh", 18'(rows[i].cmd == scd_pkg::CMD_REF), 18'(n_ref - r0));
      if (rows[i].cmd inside {scd_pkg::CMD_WR, scd_pkg::CMD_RD})
        chk_v("flags", {rows[i].pins.addr[10], rows[i].pins.addr[12]}, {cap.auto_close_flag, cap.burst_long});
      if (rows[i].cmd == scd_pkg::CMD_ACT)
        chk_v("row_bits", rows[i].pins.strobes, cap.addr[16:14]);
    end
    chk_v("otf", 18'h1, on_the_fly);
    // Deselect with steady clock enable decodes nothing
    p = rows[2].pins;
    p.cs_low = 1'b1;
    send(p);
    chk_v("deselect", 18'h0, 18'(n_valid - v0));
    // Calibration value past the last of fifty settings is flagged
    send(mk(1'h1, 3'h0, 2'h1, 2'h2, 18'h00032));
    chk_v("vref_high", 18'h3, {mode_sel == 3'h6, vref_out_of_range});
    send(mk(1'h1, 3'h0, 2'h1, 2'h2, 18'h00031));
    chk_v("vref_ok", 18'h0, vref_out_of_range);
    // Self-refresh entry, a refresh held off inside it, then exit
    @(posedge clock) on_die_termination <= 1'b1;
    p = rows[1].pins;
    p.cke = 1'b0;
    send(p);
    chk_v("sr_entry", 18'h5, {in_self_refresh, odt_active, 18'(n_ref - r0) == 18'h0});
    send(p);
    chk_v("sr_hold", 18'h3, {in_self_refresh, 18'(n_ref - r0) == 18'h0});
    p.cke = 1'b1;
    p.cs_low = 1'b1;
    send(p);
    chk_v("sr_exit", 18'h1, {in_self_refresh, odt_active});
    // Power-down entry, no refresh inside it, then exit
    p.cke = 1'b0;
    send(p);
    chk_v("pd_entry", 18'h1, in_sleep);
    p.cs_low = 1'b0;
    send(p);
    chk_v("pd_no_refresh", 18'h0, 18'(n_ref - r0));
    p.cke = 1'b1;
    p.cs_low = 1'b1;
    send(p);
    chk_v("pd_exit", 18'h0, in_sleep);
    // Burst keeps running after its command
    send(rows[5].pins);
    chk_v("burst_busy", 18'h1, burst_busy);
    // Mid-run reset returns burst mode and power state to their defaults
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (1) @(posedge clock);
    #1;
    chk_v("reset_again", 18'h0, {on_the_fly, burst_busy, in_sleep});
    @(posedge clock);
    rst_b <= 1'b1;
    // Decoding resumes cleanly after a mid-run reset
    send(rows[1].pins);
    chk_v("after_reset", 18'h1, 18'(n_ref - r0));
    stop_test();
  end
endmodule // tb_top

bind scd_command_decoder scd_decoder_chk u_chk (.clock(clock), .rst_b(rst_b), .cmd_out(cmd_out),
  .cmd_valid(cmd_valid), .bank_onehot(bank_onehot), .cluster_onehot(cluster_onehot),
  .mode_write(mode_write), .mode_sel(mode_sel), .mode_data(mode_data), .on_the_fly(on_the_fly),
  .burst_busy(burst_busy), .refresh_pulse(refresh_pulse), .odt_active(odt_active),
  .in_sleep(in_sleep), .in_self_refresh(in_self_refresh));
